// [shared/fwm_regs.vh]
/*
 * Constants of the writer-mode command port: command codes, page size,
 * status bit positions and write-cycle spacing.
 * Assumes inclusion by the command port, its bound checker and the bench.
 */
`ifndef FWM_REGS_VH
`define FWM_REGS_VH

// ==========================================================
// Command codes
`define FWM_CMD_READ        8'h00
`define FWM_CMD_PROGRAM     8'h40
`define FWM_CMD_ERASE       8'h20
`define FWM_CMD_STATUS      8'h71

// ==========================================================
// Sizes
`define FWM_DATA_W          8
`define FWM_ADDR_W          17
`define FWM_PAGE_BYTES      128
`define FWM_PAGE_LAST       7'h7F
`define FWM_PAGE_LOW_A      8'h00
`define FWM_PAGE_LOW_B      8'h80

// ==========================================================
// Polling byte bit positions
`define FWM_POLL_END_BIT    7
`define FWM_POLL_OK_BIT     6

// ==========================================================
// Return code bit positions
`define FWM_RC_NORMAL_BIT   7
`define FWM_RC_CMD_BIT      6
`define FWM_RC_PROG_BIT     5
`define FWM_RC_ERASE_BIT    4
`define FWM_RC_COUNT_BIT    1
`define FWM_RC_ADDR_BIT     0

// ==========================================================
// Command write spacing kept by the programmer
`define FWM_NXTC_US         20
`define FWM_CLK_MHZ         50
`define FWM_NXTC_CYCLES     (`FWM_NXTC_US * `FWM_CLK_MHZ)

`endif

// [logic/fwm_pin_sync.v]
/*
 * Three-stage pin synchroniser for a group of pin inputs.
 * Assumes the pins are asynchronous to i_clock; a bit changes at the
 * output only when the second and third stages agree.
 */
`timescale 1ns/10ps
`default_nettype none

module fwm_pin_sync
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
    input  wire             i_clock,
    input  wire             i_reset_n,
    input  wire [WIDTH-1:0] i_pins,
    output reg  [WIDTH-1:0] o_stable
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    genvar          g;

    // ======================================================
    // Capture chain; stage1 feeds stage2 only
    always @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end
        else
        begin
            stage1 <= i_pins;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // ======================================================
    // Per-bit agreement filter
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            always @(posedge i_clock)
            begin
                if (!i_reset_n)
                    o_stable[g] <= INIT[g];
                else if (stage2[g] == stage3[g])
                    o_stable[g] <= stage3[g];
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [logic/fwm_skid2.v]
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes producer and consumer on i_clock; full and empty are exact.
 */
`timescale 1ns/10ps
`default_nettype none

module fwm_skid2
#(
    parameter WIDTH = 8
)
(
    input  wire             i_clock,
    input  wire             i_reset_n,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output reg  [WIDTH-1:0] o_out_data
);

    reg [WIDTH-1:0] spare;
    reg [1:0]       count;
    wire            push;
    wire            pop;

    assign o_in_ready  = (count != 2'd2);
    assign o_out_valid = (count != 2'd0);
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // ======================================================
    // Head register drives the output; spare holds the second word
    always @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            count      <= 2'd0;
            spare      <= {WIDTH{1'b0}};
            o_out_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (pop)
            begin
                if (count == 2'd2)
                    o_out_data <= spare;
                else if (push)
                    o_out_data <= i_in_data;
            end
            else if (push && count == 2'd0)
                o_out_data <= i_in_data;
            if (push && ((count == 2'd1 && !pop) || (count == 2'd2 && pop)))
                spare <= i_in_data;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

`default_nettype wire

// [logic/fwm_command_port.v]
/*
 * Writer-mode command port: decodes the programmer's strobes, runs the
 * read, program, erase and status modes and drives the data pins.
 * Assumes a flash array engine on i_clock that answers reads combinationally
 * within a cycle, takes program bytes by valid/ready and pulses
 * i_op_done at the end of each program or erase.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fwm_regs.vh"

module fwm_command_port
(
    input  wire                     i_clock,
    input  wire                     i_reset_n,
    input  wire                     i_chip_sel_n,
    input  wire                     i_out_en_n,
    input  wire                     i_write_n,
    input  wire                     i_flash_write_permit_pin,
    input  wire [`FWM_ADDR_W-1:0]   i_flash_address_in,
    input  wire [`FWM_DATA_W-1:0]   i_flash_data_io,
    output reg  [`FWM_DATA_W-1:0]   o_flash_data_io,
    output wire                     o_flash_data_oe,
    output reg  [`FWM_ADDR_W-1:0]   o_read_address,
    input  wire [`FWM_DATA_W-1:0]   i_array_data,
    output wire                     o_prog_valid,
    input  wire                     i_prog_ready,
    output wire [`FWM_ADDR_W-1:0]   o_program_address,
    output wire [`FWM_DATA_W-1:0]   o_prog_data,
    output reg                      o_prog_start,
    output reg                      o_erase_start,
    input  wire                     i_op_done,
    input  wire                     i_prog_fail,
    input  wire                     i_erase_fail,
    input  wire                     i_count_over,
    output wire                     o_busy
);

    // ======================================================
    // States
    localparam [6:0] ST_READ    = 7'h01;
    localparam [6:0] ST_WAIT    = 7'h02;
    localparam [6:0] ST_ERA_ARM = 7'h04;
    localparam [6:0] ST_STS_ARM = 7'h08;
    localparam [6:0] ST_LOAD    = 7'h10;
    localparam [6:0] ST_PROG    = 7'h20;
    localparam [6:0] ST_ERASE   = 7'h40;
    localparam       PIN_W      = 4 + `FWM_ADDR_W + `FWM_DATA_W;
    localparam       BUF_W      = `FWM_ADDR_W + `FWM_DATA_W;

    // Low byte of a page start address is one of two values
    function page_low_ok;
        input [7:0] low;
        begin
            page_low_ok = (low == `FWM_PAGE_LOW_A) || (low == `FWM_PAGE_LOW_B);
        end
    endfunction

    // ======================================================
    // Pin synchronisation; strobes reset to their idle high level
    wire [PIN_W-1:0]        pins_stable;
    wire                    cs_n;
    wire                    oe_n;
    wire                    we_n;
    wire                    permit;
    wire [`FWM_ADDR_W-1:0]  pin_addr;
    wire [`FWM_DATA_W-1:0]  pin_data;

    fwm_pin_sync
    #(
        .WIDTH (PIN_W),
        .INIT  ({3'b111, {(PIN_W-3){1'b0}}})
    )
    u_sync
    (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_pins    ({i_chip_sel_n, i_out_en_n, i_write_n,
                     i_flash_write_permit_pin, i_flash_address_in,
                     i_flash_data_io}),
        .o_stable  (pins_stable)
    );

    assign {cs_n, oe_n, we_n, permit, pin_addr, pin_data} = pins_stable;

    // ======================================================
    // Write strobe edge; only a selected, output-disabled cycle counts
    reg  we_prev;
    reg  cycle_sel;
    wire wr_event;

    always @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            we_prev   <= 1'b1;
            cycle_sel <= 1'b0;
        end
        else
        begin
            we_prev   <= we_n;
            cycle_sel <= !cs_n && oe_n && !we_n;
        end
    end

    assign wr_event = we_n && !we_prev && cycle_sel;

    // Bus driven only in a selected read cycle
    assign o_flash_data_oe = !cs_n && !oe_n && we_n;

    // ======================================================
    // Pending write holds a taken cycle until it can be used
    reg                     pend;
    reg [`FWM_DATA_W-1:0]   pend_data;
    reg [`FWM_ADDR_W-1:0]   pend_addr;
    reg                     pend_permit;
    wire                    consume;

    always @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            pend        <= 1'b0;
            pend_data   <= 8'h00;
            pend_addr   <= 17'h00000;
            pend_permit <= 1'b0;
        end
        else
        begin
            // A new write wins over the clear of the old one
            if (wr_event)
            begin
                pend        <= 1'b1;
                pend_data   <= pin_data;
                pend_addr   <= pin_addr;
                pend_permit <= permit;
            end
            else if (consume)
                pend <= 1'b0;
        end
    end

    // ======================================================
    // Program byte buffer; a stall by the array engine holds the write
    wire buf_in_ready;
    wire push;

    fwm_skid2
    #(
        .WIDTH (BUF_W)
    )
    u_buf
    (
        .i_clock     (i_clock),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (push),
        .o_in_ready  (buf_in_ready),
        .i_in_data   ({pend_addr, pend_data}),
        .o_out_valid (o_prog_valid),
        .i_out_ready (i_prog_ready),
        .o_out_data  ({o_program_address, o_prog_data})
    );

    // ======================================================
    // Sequencer state
    reg [6:0]   state;
    reg [6:0]   next_state;
    reg [6:0]   byte_count;
    reg         op_end;
    reg         show_code;
    reg         err_cmd;
    reg         err_prog;
    reg         err_erase;
    reg         err_count;
    reg         err_addr;
    reg         prog_issued;
    wire        in_load;
    wire        any_err;

    assign in_load = (state == ST_LOAD);
    assign push    = pend && in_load && buf_in_ready;
    // In load mode a byte leaves only when the buffer takes it
    assign consume = pend && (!in_load || buf_in_ready);
    assign any_err = err_cmd | err_prog | err_erase | err_count | err_addr;
    assign o_busy  = (state == ST_PROG) || (state == ST_ERASE);

    // ======================================================
    // Next-state decode of commands and engine events
    always @*
    begin
        next_state = state;
        case (state)
            ST_READ, ST_WAIT:
            begin
                // Read mode decodes exactly like the wait state
                if (pend)
                begin
                    if (pend_data == `FWM_CMD_READ)
                        next_state = ST_READ;
                    else if (pend_data == `FWM_CMD_PROGRAM && pend_permit)
                        next_state = ST_LOAD;
                    else if (pend_data == `FWM_CMD_ERASE && pend_permit)
                        next_state = ST_ERA_ARM;
                    else if (pend_data == `FWM_CMD_STATUS)
                        next_state = ST_STS_ARM;
                    else
                        next_state = ST_WAIT;
                end
            end
            ST_ERA_ARM:
            begin
                if (pend)
                begin
                    if (pend_data == `FWM_CMD_ERASE && pend_permit)
                        next_state = ST_ERASE;
                    else
                        next_state = ST_WAIT;
                end
            end
            ST_STS_ARM:
            begin
                if (pend)
                    next_state = ST_WAIT;
            end
            ST_LOAD:
            begin
                if (push && byte_count == `FWM_PAGE_LAST)
                    next_state = ST_PROG;
            end
            ST_PROG, ST_ERASE:
            begin
                if (i_op_done && (state == ST_ERASE || prog_issued))
                    next_state = ST_WAIT;
            end
            default:
                next_state = ST_READ;
        endcase
    end

    // ======================================================
    // State, counters and status flags
    // Writes during a running operation are dropped: the engine owns the array
    always @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            state         <= ST_READ;
            byte_count    <= 7'h00;
            op_end        <= 1'b0;
            show_code     <= 1'b0;
            err_cmd       <= 1'b0;
            err_prog      <= 1'b0;
            err_erase     <= 1'b0;
            err_count     <= 1'b0;
            err_addr      <= 1'b0;
            prog_issued   <= 1'b0;
            o_prog_start  <= 1'b0;
            o_erase_start <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            o_prog_start  <= 1'b0;
            o_erase_start <= 1'b0;
            // Any command write ends the polling display
            if (pend && (state == ST_READ || state == ST_WAIT))
            begin
                op_end    <= 1'b0;
                show_code <= 1'b0;
                if (pend_data != `FWM_CMD_STATUS)
                begin
                    err_cmd   <= 1'b0;
                    err_prog  <= 1'b0;
                    err_erase <= 1'b0;
                    err_count <= 1'b0;
                    err_addr  <= 1'b0;
                end
                if (next_state == ST_WAIT)
                    err_cmd <= 1'b1;
                byte_count  <= 7'h00;
                prog_issued <= 1'b0;
            end
            if (pend && state == ST_ERA_ARM)
            begin
                if (next_state == ST_ERASE)
                    o_erase_start <= 1'b1;
                else
                    err_cmd <= 1'b1;
            end
            if (pend && state == ST_STS_ARM)
            begin
                if (pend_data == `FWM_CMD_STATUS)
                    show_code <= 1'b1;
                else
                    err_cmd <= 1'b1;
            end
            if (push)
            begin
                byte_count <= byte_count + 7'h01;
                // Page start checked on the first data write only
                if (byte_count == 7'h00 && !page_low_ok(pend_addr[7:0]))
                    err_addr <= 1'b1;
            end
            // Programming starts once every byte has reached the engine
            if (state == ST_PROG && !prog_issued && !o_prog_valid)
            begin
                o_prog_start <= 1'b1;
                prog_issued  <= 1'b1;
            end
            if (o_busy && next_state == ST_WAIT)
            begin
                op_end    <= 1'b1;
                err_prog  <= err_prog | i_prog_fail;
                err_erase <= err_erase | i_erase_fail;
                err_count <= err_count | i_count_over;
            end
        end
    end

    // ======================================================
    // Read address follows the pins while in read mode
    always @(posedge i_clock)
    begin
        if (!i_reset_n)
            o_read_address <= 17'h00000;
        else if (state == ST_READ)
            o_read_address <= pin_addr;
    end

    // ======================================================
    // Output byte: array data, return code or polling byte
    always @(posedge i_clock)
    begin
        if (!i_reset_n)
            o_flash_data_io <= 8'h00;
        else if (state == ST_READ)
            o_flash_data_io <= i_array_data;
        else if (show_code)
        begin
            o_flash_data_io <= 8'h00;
            o_flash_data_io[`FWM_RC_NORMAL_BIT] <= !any_err;
            o_flash_data_io[`FWM_RC_CMD_BIT]    <= err_cmd;
            o_flash_data_io[`FWM_RC_PROG_BIT]   <= err_prog;
            o_flash_data_io[`FWM_RC_ERASE_BIT]  <= err_erase;
            o_flash_data_io[`FWM_RC_COUNT_BIT]  <= err_count;
            o_flash_data_io[`FWM_RC_ADDR_BIT]   <= err_addr;
        end
        else
        begin
            o_flash_data_io <= 8'h00;
            o_flash_data_io[`FWM_POLL_END_BIT] <= op_end;
            o_flash_data_io[`FWM_POLL_OK_BIT]  <= op_end && !any_err;
        end
    end

endmodule

`default_nettype wire

// [bench/fwm_port_checker.sv]
/* Checker on the command port pins and engine side.
   Bound into every fwm_command_port; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
`include "fwm_regs.vh"

module fwm_port_checker
(
    input wire logic                   i_clock,
    input wire logic                   i_reset_n,
    input wire logic                   i_chip_sel_n,
    input wire logic                   i_out_en_n,
    input wire logic                   i_write_n,
    input wire logic                   o_flash_data_oe,
    input wire logic                   o_prog_valid,
    input wire logic                   i_prog_ready,
    input wire logic [`FWM_ADDR_W-1:0] o_program_address,
    input wire logic [`FWM_DATA_W-1:0] o_prog_data,
    input wire logic                   o_prog_start,
    input wire logic                   o_erase_start,
    input wire logic                   i_op_done,
    input wire logic                   o_busy
);
    // ====
    // Clock and reset given once
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    // ====
    // Pin decode; six edges cover the synchronisers
    desel_float_a: assert property (i_chip_sel_n [*6] |-> !o_flash_data_oe)
        else $error("Pins driven while deselected");
    read_drive_a: assert property (
        (!i_chip_sel_n && !i_out_en_n && i_write_n) [*6] |-> o_flash_data_oe)
        else $error("Read strobes left pins floating");
    idle_float_a: assert property (
        (!i_chip_sel_n && i_out_en_n && i_write_n) [*6] |-> !o_flash_data_oe)
        else $error("Pins driven with output enable off");

    // ====
    // Engine side
    prog_pulse_a: assert property (o_prog_start |=> !o_prog_start)
        else $error("Program start longer than one cycle");
    erase_pulse_a: assert property (o_erase_start |=> !o_erase_start)
        else $error("Erase start longer than one cycle");
    start_busy_a: assert property ((o_prog_start || o_erase_start) |-> o_busy)
        else $error("Start issued while not busy");
    done_idle_a: assert property (
        (o_prog_start || o_erase_start) ##[1:200] i_op_done |=> !o_busy)
        else $error("Still busy after done");
    byte_hold_a: assert property (
        o_prog_valid && !i_prog_ready |=>
        o_prog_valid && $stable(o_prog_data) && $stable(o_program_address))
        else $error("Program byte changed while stalled");
    drained_a: assert property (o_prog_start |-> !o_prog_valid)
        else $error("Programming began with bytes queued");
endmodule

bind fwm_command_port fwm_port_checker u_fwm_port_checker
(
    .i_clock, .i_reset_n, .i_chip_sel_n, .i_out_en_n, .i_write_n,
    .o_flash_data_oe, .o_prog_valid, .i_prog_ready, .o_program_address,
    .o_prog_data, .o_prog_start, .o_erase_start, .i_op_done, .o_busy
);

`default_nettype wire

// [bench/fwm_prog_model.sv]
/* Programmer model: drives strobes, address and data pins.
   Assumes the bench calls one task at a time. */
`timescale 1ns/10ps
`default_nettype none

module fwm_prog_model
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_dout,
    input  wire logic       i_doe,
    output logic            o_cs_n,
    output logic            o_oe_n,
    output logic            o_we_n,
    output logic            o_permit,
    output logic [16:0]     o_addr,
    output wire logic [7:0] o_pins
);
    logic       drive = 1'b0;
    logic [7:0] wdata = 8'h00;

    // ====
    // Idle pins; permit stays high so every start is allowed
    initial
    begin
        o_cs_n   = 1'b1;
        o_oe_n   = 1'b1;
        o_we_n   = 1'b1;
        o_permit = 1'b1;
        o_addr   = 17'h00000;
    end

    // Released pins show the inverse, so stale data never reads back
    assign o_pins = i_doe ? i_dout : (drive ? wdata : ~wdata);

    // ====
    // Write cycle, then the caller's spacing
    task automatic wr(input logic [7:0] d, input logic [16:0] a, input int gap);
        @(posedge i_clock);
        o_addr <= a;
        wdata  <= d;
        drive  <= 1'b1;
        o_cs_n <= 1'b0;
        o_we_n <= 1'b0;
        repeat (5) @(posedge i_clock);
        o_we_n <= 1'b1;
        repeat (5) @(posedge i_clock);
        o_cs_n <= 1'b1;
        drive  <= 1'b0;
        repeat (gap) @(posedge i_clock);
    endtask

    // Read cycle; sampled once the synchronisers have settled
    task automatic rd(input logic [16:0] a, output logic [7:0] q, output logic en);
        @(posedge i_clock);
        o_addr <= a;
        o_cs_n <= 1'b0;
        o_oe_n <= 1'b0;
        repeat (10) @(posedge i_clock);
        #1;
        q = o_pins;
        en = i_doe;
        @(posedge i_clock);
        o_cs_n <= 1'b1;
        o_oe_n <= 1'b1;
    endtask

    // Parks the strobes with no access
    task automatic park(input logic cs);
        @(posedge i_clock);
        o_cs_n <= cs;
    endtask
endmodule

`default_nettype wire

// [bench/flash_writer_mode_command_port_bench.sv]
/* Bench for the command port: programmer model on the pins,
   behavioural flash engine on the array side. */
`timescale 1ns/10ps
`default_nettype none
`include "fwm_regs.vh"

module flash_writer_mode_command_port_bench;
    logic             i_clock;
    logic             i_reset_n;
    logic             i_prog_ready = 1'b0;
    logic             i_op_done = 1'b0;
    logic             i_erase_fail = 1'b0;
    logic             wiping = 1'b0;
    logic [7:0]       taken = 8'h00;
    logic [7:0]       dly = 8'h00;
    logic [7:0]       cyc = 8'h00;
    logic [7:0]       mem [0:131071];
    int               mismatches = 0;
    int               num_checks = 0;
    wire logic        i_chip_sel_n, i_out_en_n, i_write_n, i_flash_write_permit_pin;
    wire logic        o_flash_data_oe, o_prog_valid, o_prog_start, o_erase_start, o_busy;
    wire logic [16:0] i_flash_address_in, o_read_address, o_program_address;
    wire logic [7:0]  i_flash_data_io, o_flash_data_io, i_array_data, o_prog_data;

    // ====
    // Clock and instances
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    fwm_command_port u_fwm_command_port
    (
        .i_clock, .i_reset_n, .i_chip_sel_n, .i_out_en_n, .i_write_n,
        .i_flash_write_permit_pin, .i_flash_address_in, .i_flash_data_io,
        .o_flash_data_io, .o_flash_data_oe, .o_read_address, .i_array_data,
        .o_prog_valid, .i_prog_ready, .o_program_address, .o_prog_data,
        .o_prog_start, .o_erase_start, .i_op_done, .i_prog_fail(1'b0),
        .i_erase_fail, .i_count_over(1'b0), .o_busy
    );

    fwm_prog_model u_fwm_prog_model
    (
        .i_clock(i_clock), .i_dout(o_flash_data_io), .i_doe(o_flash_data_oe),
        .o_cs_n(i_chip_sel_n), .o_oe_n(i_out_en_n), .o_we_n(i_write_n),
        .o_permit(i_flash_write_permit_pin), .o_addr(i_flash_address_in),
        .o_pins(i_flash_data_io)
    );

    // ====
    // Engine: 16-cycle stalls stay within the two-entry buffer
    assign i_array_data = mem[o_read_address];

    initial
        for (int k = 0; k < 131072; k++)
            mem[k] = k[7:0];

    always @(posedge i_clock)
    begin
        cyc <= cyc + 8'h01;
        i_prog_ready <= cyc[4];
        i_op_done <= 1'b0;
        if (o_prog_valid && i_prog_ready)
        begin
            mem[o_program_address] <= o_prog_data;
            taken <= taken + 8'h01;
        end
        if (o_prog_start || o_erase_start)
        begin
            dly <= 8'h28;
            wiping <= o_erase_start;
        end
        else if (dly != 8'h00)
        begin
            dly <= dly - 8'h01;
            i_op_done <= (dly == 8'h01);
            if (wiping && dly == 8'h01)
                for (int j = 0; j < 131072; j++)
                    mem[j] <= 8'hFF;
        end
    end

    // ====
    // Shared steps
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic look(input logic [16:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       en;
        u_fwm_prog_model.rd(a, q, en);
        chk({7'h00, en}, 8'h01);
        chk(q, exp);
    endtask

    task automatic cmd(input logic [7:0] d);
        u_fwm_prog_model.wr(d, 17'h00000, `FWM_NXTC_CYCLES);
    endtask

    task automatic page(input logic [16:0] base);
        cmd(8'h40);
        for (int i = 0; i < 128; i++)
            u_fwm_prog_model.wr(8'(i) ^ 8'hA5, base + 17'(i), 4);
        #1;
        chk({7'h00, o_busy}, 8'h01);
        for (int n = 0; o_busy !== 1'b0; n++)
        begin
            if (n == 2000)
            begin
                mismatches++;
                $display("FAIL %0t engine never finished", $time);
                tally_and_finish();
            end
            @(posedge i_clock);
            #1;
        end
    endtask

    // ====
    // Scenarios
    task automatic t_power_read();
        look(17'h1ABCD, 8'hCD);
        look(17'h00012, 8'h12);
        u_fwm_prog_model.park(1'b0);
        repeat (8) @(posedge i_clock);
        #1;
        chk({7'h00, o_flash_data_oe}, 8'h00);
        u_fwm_prog_model.park(1'b1);
        repeat (8) @(posedge i_clock);
        #1;
        chk({7'h00, o_flash_data_oe}, 8'h00);
    endtask

    task automatic t_erase();
        cmd(8'h20);
        cmd(8'h20);
        look(17'h00000, 8'hC0);
        look(17'h00000, 8'hC0);
        cmd(8'h00);
        look(17'h1ABCD, 8'hFF);
    endtask

    task automatic t_program();
        logic [7:0] t0;
        t0 = taken;
        page(17'h00100);
        chk(taken - t0, 8'h80);
        look(17'h00000, 8'hC0);
        cmd(8'h00);
        look(17'h00100, 8'hA5);
        look(17'h0017F, 8'hDA);
    endtask

    task automatic t_errors();
        cmd(8'h55);
        cmd(8'h71);
        cmd(8'h71);
        look(17'h00000, 8'h40);
        page(17'h00240);
        look(17'h00000, 8'h80);
        cmd(8'h71);
        cmd(8'h71);
        look(17'h00000, 8'h01);
        i_erase_fail <= 1'b1;
        cmd(8'h20);
        cmd(8'h20);
        look(17'h00000, 8'h80);
        cmd(8'h71);
        cmd(8'h71);
        look(17'h00000, 8'h10);
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ====
    // Main sequence
    initial
    begin
        i_reset_n = 1'b0;
        repeat (3) @(posedge i_clock);
        i_reset_n <= 1'b1;
        t_power_read();
        t_erase();
        t_program();
        t_errors();
        tally_and_finish();
    end
endmodule

`default_nettype wire
